// [core/rbw_field_reg.sv]
`default_nettype none
module rbw_field_reg
  import rbw_pkg::*;
(
  input wire logic clk_in,  // System clock.
  input wire logic reset_n_in,  // Async reset, active low.
  input wire logic load_in,  // Capture strobe.
  input wire logic [LGL_W-1:0] data_in,  // Value to hold.
  output logic [LGL_W-1:0] data_out  // Held value.
);
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      data_out <= LGL_RESET;
    else if (load_in)
      data_out <= data_in;
  end
endmodule
`default_nettype wire

// [core/rbw_loop_check.sv]
`default_nettype none
module rbw_loop_check
  import rbw_pkg::*;
(
  input wire logic clk_in,  // System clock.
  input wire logic reset_n_in,  // Async reset, active low.
  input wire logic enable_in,  // Checking enabled.
  input wire logic sent_valid_in,  // Word sent, pulse.
  input wire logic [CMD_W-1:0] sent_word_in,  // Word sent.
  input wire logic echo_valid_in,  // Word echoed, pulse.
  input wire logic [CMD_W-1:0] echo_word_in,  // Word echoed.
  output logic fail_out  // Mismatch or missing echo.
);
  logic [CMD_W-1:0] expect_word;
  logic waiting;
  // A new send while still waiting, with no echo in the same cycle, counts as a lost echo.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      waiting <= 1'b0;
      expect_word <= '0;
      fail_out <= 1'b0;
    end
    else if (!enable_in)
    begin
      waiting <= 1'b0;
      fail_out <= 1'b0;
    end
    else
    begin
      if (echo_valid_in && (!waiting || echo_word_in != expect_word))
        fail_out <= 1'b1;
      if (sent_valid_in && waiting && !echo_valid_in)
        fail_out <= 1'b1;
      if (sent_valid_in)
      begin
        waiting <= 1'b1;
        expect_word <= sent_word_in;
      end
      else if (echo_valid_in)
        waiting <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [core/rbw_pkg.sv]
`default_nettype none
package rbw_pkg;
  // Command word field positions (bit time 4 is the word's MSB, index 15).
  localparam int CMD_W = 16;
  localparam int LGL_W = 11;
  localparam int LGL_HI = 10;  // Command bit time 9 sits at index 10.
  localparam int WC_W = 5;
  // Register map on the plain register port.
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STATE = 4'h2;
  localparam logic [3:0] ADDR_LGLBUS = 4'h3;
  localparam int EV_W = 3;
  localparam int EV_BUSY_IN = 0;
  localparam int EV_BUSY_OUT = 1;
  localparam int EV_WRAP_FAIL = 2;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam logic [LGL_W-1:0] LGL_RESET = 11'h000;
  typedef enum logic [1:0] {RBW_IDLE, RBW_PENDING, RBW_BUSY} rbw_busy_t;
endpackage
`default_nettype wire

// [core/rbw_top.sv]
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module rbw_top
  import rbw_pkg::*;
(
  input wire logic clk_in,  // 25 MHz system clock.
  input wire logic reset_n_in,  // Async reset, active low.
  input wire logic force_busy_req_n,  // Busy request, active low.
  output logic busy_entered_n,  // Busy entered, active low.
  input wire logic msg_active_in,  // Message in progress.
  input wire logic msg_last_dma_done_in,  // Last transfer done, pulse.
  input wire logic dma_req_in,  // Core wants a memory access.
  output logic dma_req_out,  // Gated memory request.
  output logic mem_bus_oe_n_out,  // Memory bus enable, low drives.
  output logic status_busy_bit_out,  // Busy bit for status word.
  output logic auto_busy_reply_out,  // Reply without memory.
  input wire logic loop_check_en_n,  // Loop check enable, low.
  input wire logic cross_channel_diag_n,  // Cross diag, low.
  input wire logic tx_chan_b_in,  // Sending on channel B.
  input wire logic sent_valid_in,  // Word sent, pulse.
  input wire logic [CMD_W-1:0] sent_word_in,  // Word sent.
  input wire logic echo_a_valid_in,  // Channel A echo, pulse.
  input wire logic [CMD_W-1:0] echo_a_word_in,  // Channel A echo.
  input wire logic echo_b_valid_in,  // Channel B echo, pulse.
  input wire logic [CMD_W-1:0] echo_b_word_in,  // Channel B echo.
  output logic loop_check_fail,  // Loop check failed.
  input wire logic cmd_valid_in,  // Command validated, pulse.
  input wire logic [CMD_W-1:0] cmd_word_in,  // Command word.
  input wire logic legal_sampled_in,  // Legality sampled, pulse.
  input wire logic err_valid_in,  // Data word error, pulse.
  input wire logic [WC_W-1:0] err_word_count_in,  // Faulty word count.
  input wire logic legality_method_sel,  // High memory, low bus.
  input wire logic error_convention_sel,  // High standard.
  input wire logic command_legal_in,  // Legal from user logic.
  output logic legality_logic_en_n,  // User logic enable, low.
  output logic cmd_legal_out,  // Sampled legality.
  output logic [LGL_W-1:0] cmd_field_bus,  // Field bus, bit 10 msb.
  input wire logic [3:0] reg_addr_in,  // Register address.
  input wire logic [7:0] reg_wdata_in,  // Write data.
  input wire logic reg_wr_in,  // Write strobe.
  input wire logic reg_rd_in,  // Read strobe.
  output logic [7:0] reg_rdata_out,  // Read data, next cycle.
  output logic irq_out  // Interrupt, active high level.
);
  rbw_busy_t state;
  logic busy_req;
  logic [LGL_W-1:0] field_next;
  logic field_load;
  logic holding;
  logic echo_valid;
  logic [CMD_W-1:0] echo_word;
  logic diag_mode;
  logic fail_q;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] events;

  function automatic logic [LGL_W-1:0] cmd_fields(
    input logic [CMD_W-1:0] w);
    cmd_fields = w[LGL_HI -: LGL_W];
  endfunction

  assign busy_req = !force_busy_req_n;

  // Forced busy sequencer.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= RBW_IDLE;
    else
      case (state)
        RBW_IDLE:
          if (busy_req)
            state <= msg_active_in ? RBW_PENDING : RBW_BUSY;
        RBW_PENDING:
          if (!busy_req)
            state <= RBW_IDLE;
          else if (msg_last_dma_done_in || !msg_active_in)
            state <= RBW_BUSY;
        RBW_BUSY:
          if (!busy_req)
            state <= RBW_IDLE;
        default:
          state <= RBW_IDLE;
      endcase
  end

  assign busy_entered_n = (state != RBW_BUSY);
  assign status_busy_bit_out = (state == RBW_BUSY);
  assign auto_busy_reply_out = (state == RBW_BUSY);
  assign dma_req_out = dma_req_in && (state != RBW_BUSY);
  // Buses float whenever the core is not actually holding a request.
  assign mem_bus_oe_n_out = !dma_req_out;

  // Cross-channel diagnostic: echo taken from the other channel.
  assign diag_mode = !loop_check_en_n && !cross_channel_diag_n;
  always_comb
  begin
    if (diag_mode ^ tx_chan_b_in)
    begin
      echo_valid = echo_b_valid_in;
      echo_word = echo_b_word_in;
    end
    else
    begin
      echo_valid = echo_a_valid_in;
      echo_word = echo_a_word_in;
    end
  end

  rbw_loop_check u_check (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(!loop_check_en_n),
    .sent_valid_in(sent_valid_in),
    .sent_word_in(sent_word_in),
    .echo_valid_in(echo_valid),
    .echo_word_in(echo_word),
    .fail_out(fail_q)
  );
  assign loop_check_fail = fail_q;

  // Field bus: a new command is blocked while legality is pending.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      holding <= 1'b0;
    else if (cmd_valid_in && !holding)
      holding <= 1'b1;
    else if (legal_sampled_in)
      holding <= 1'b0;
  end

  always_comb
  begin
    field_load = 1'b0;
    field_next = cmd_field_bus;
    if (err_valid_in && !error_convention_sel)
    begin
      field_load = 1'b1;
      field_next = {cmd_field_bus[LGL_W-1:WC_W], err_word_count_in};
    end
    else if (cmd_valid_in && !holding)
    begin
      field_load = 1'b1;
      field_next = cmd_fields(cmd_word_in);
    end
  end

  rbw_field_reg u_field (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .load_in(field_load),
    .data_in(field_next),
    .data_out(cmd_field_bus)
  );

  assign legality_logic_en_n = legality_method_sel;

  // Legality result; memory method treats every command as legal here.
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cmd_legal_out <= 1'b0;
    else if (legal_sampled_in)
      cmd_legal_out <= legality_method_sel || command_legal_in;
  end

  // Interrupts: sticky status, write one to clear, set wins.
  always_comb
  begin
    events = '0;
    events[EV_BUSY_IN] = (state != RBW_BUSY) && busy_req &&
      (state == RBW_IDLE ? !msg_active_in :
        (msg_last_dma_done_in || !msg_active_in));
    events[EV_BUSY_OUT] = (state == RBW_BUSY) && !busy_req;
    // A failure stays set while checking runs, so the bit keeps setting.
    events[EV_WRAP_FAIL] = fail_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status <= '0;
    else if (reg_wr_in && reg_addr_in == ADDR_STATUS)
      status <= (status & ~reg_wdata_in[EV_W-1:0]) | events;
    else
      status <= status | events;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      mask <= MASK_RESET;
    else if (reg_wr_in && reg_addr_in == ADDR_MASK)
      mask <= reg_wdata_in[EV_W-1:0];
  end

  assign irq_out = |(status & mask);

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      case (reg_addr_in)
        ADDR_STATUS: reg_rdata_out <= {5'h00, status};
        ADDR_MASK: reg_rdata_out <= {5'h00, mask};
        ADDR_STATE: reg_rdata_out <= {4'h0, holding, fail_q,
          !busy_entered_n, state == RBW_PENDING};
        ADDR_LGLBUS: reg_rdata_out <= cmd_field_bus[7:0];
        default: reg_rdata_out <= 8'h00;
      endcase
    else
      reg_rdata_out <= 8'h00;
  end

  AST_BUSY_NO_DMA: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !busy_entered_n |-> !dma_req_out && mem_bus_oe_n_out)
    else $error("Memory access while busy.");
  AST_BUSY_FLOAT: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    state == RBW_BUSY && busy_req |=> mem_bus_oe_n_out)
    else $error("Memory bus driven in busy state.");
  AST_BUSY_HELD_OFF: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    msg_active_in && !msg_last_dma_done_in && busy_entered_n
    |=> busy_entered_n)
    else $error("Busy entered during message.");
  AST_BUSY_WAIT_END: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    state == RBW_PENDING && busy_req && msg_last_dma_done_in
    |=> !busy_entered_n)
    else $error("Busy not entered after last transfer.");
  AST_BUSY_ENTRY: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    busy_req && !msg_active_in && state == RBW_IDLE |=> !busy_entered_n)
    else $error("Busy not entered.");
  AST_BUSY_EXIT: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !busy_req |=> busy_entered_n)
    else $error("Busy not released.");
  AST_STATUS_BIT: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    status_busy_bit_out == !busy_entered_n &&
    auto_busy_reply_out == !busy_entered_n)
    else $error("Status busy bit mismatch.");
  // The bus is the low part of the command word, bit time 9 at its top.
  AST_FIELD_MAP: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    cmd_valid_in && !holding && !err_valid_in
    |=> cmd_field_bus == LGL_W'($past(cmd_word_in)))
    else $error("Field bus wrong.");
  AST_FIELD_HOLD: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    holding && !legal_sampled_in && !err_valid_in
    |=> $stable(cmd_field_bus))
    else $error("Field bus changed.");
  AST_ERR_COUNT: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    err_valid_in && !error_convention_sel
    |=> cmd_field_bus[WC_W-1:0] == $past(err_word_count_in))
    else $error("Word count missing.");
  AST_LGL_EN: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    legality_logic_en_n == legality_method_sel)
    else $error("Legality enable wrong.");
  AST_LEGAL_TAKEN: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    legal_sampled_in && !legality_method_sel
    |=> cmd_legal_out == $past(command_legal_in))
    else $error("Legality verdict not taken.");
  AST_LEGAL_MEM: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    legal_sampled_in && legality_method_sel |=> cmd_legal_out)
    else $error("Memory method verdict wrong.");
  AST_LOOP_OFF: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    loop_check_en_n |=> !loop_check_fail)
    else $error("Fail while check off.");
  AST_LOOP_FAIL: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !loop_check_en_n && sent_valid_in ##1 !loop_check_en_n && echo_valid &&
    echo_word != $past(sent_word_in) |=> loop_check_fail)
    else $error("Echo mismatch not flagged.");
  AST_DIAG_ECHO: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    diag_mode && !tx_chan_b_in |-> echo_valid == echo_b_valid_in &&
    echo_word == echo_b_word_in)
    else $error("Diagnostic echo from wrong channel.");
  AST_FAIL_STATUS: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    loop_check_fail |=> status[EV_WRAP_FAIL])
    else $error("Loop failure not logged.");
endmodule
`default_nettype wire

// [test/rbw_legal_model.sv]
`default_nettype none
module rbw_legal_model
  import rbw_pkg::*;
#(
  parameter logic [4:0] BAD_SUBADDR = 5'h1E,
  parameter bit SLOW = 1'b0
)
(
  input wire logic clk_in,  // System clock.
  input wire logic en_n_in,  // Enable from the block, active low.
  input wire logic [LGL_W-1:0] field_in,  // Command fields.
  output logic legal_out  // Verdict to the block.
);
  logic verdict;
  logic last = 1'b0;
  // Bus bits 9 to 5 carry the subaddress; one subaddress is refused.
  assign verdict = (field_in[9:5] != BAD_SUBADDR);
  // A disabled source leaves no stale level, so the idle value flips.
  always @(posedge clk_in)
  begin
    last <= en_n_in ? ~last : verdict;
  end
  assign legal_out = (en_n_in || SLOW) ? last : verdict;
endmodule
`default_nettype wire

// [test/rbw_top_tb_top.sv]
`default_nettype none
module rbw_top_tb_top
  import rbw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0, reset_n_in = 1'h0;
  logic force_busy_req_n = 1'h1, msg_active_in = 1'h0, dma_req_in = 1'h0;
  logic msg_last_dma_done_in = 1'h0, busy_entered_n, dma_req_out;
  logic mem_bus_oe_n_out, status_busy_bit_out, auto_busy_reply_out;
  logic loop_check_en_n = 1'h1, cross_channel_diag_n = 1'h1;
  logic tx_chan_b_in = 1'h0, sent_valid_in = 1'h0, loop_check_fail;
  logic echo_a_valid_in = 1'h0, echo_b_valid_in = 1'h0;
  logic [CMD_W-1:0] sent_word_in = '0, echo_a_word_in = '0;
  logic [CMD_W-1:0] echo_b_word_in = '0, cmd_word_in = '0;
  logic cmd_valid_in = 1'h0, legal_sampled_in = 1'h0, err_valid_in = 1'h0;
  logic [WC_W-1:0] err_word_count_in = '0;
  logic legality_method_sel = 1'h0, error_convention_sel = 1'h1;
  logic command_legal_in, legality_logic_en_n, cmd_legal_out, irq_out;
  logic [LGL_W-1:0] cmd_field_bus;
  logic [3:0] reg_addr_in = '0;
  logic [7:0] reg_wdata_in = '0, reg_rdata_out;
  logic reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  int err_total = 0, samples_checked = 0, cycles = 0;

  rbw_top i_dut (.*);
  rbw_legal_model #(.SLOW(1'b1)) i_model (.clk_in(clk_in),
    .en_n_in(legality_logic_en_n), .field_in(cmd_field_bus),
    .legal_out(command_legal_in));

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang in any handshake ends the run here instead of stalling forever.
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1 chk(n, e, reg_rdata_out);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
    #1;
  endtask

  task automatic t_busy(input logic in_msg);
    @(posedge clk_in);
    dma_req_in <= 1'h1;
    msg_active_in <= in_msg;
    force_busy_req_n <= 1'h0;
    if (in_msg)
    begin
      tick(3);
      chk("busy_held_off", 1'h1, busy_entered_n);
      chk("dma_in_msg", 1'h1, dma_req_out);
      @(posedge clk_in);
      msg_last_dma_done_in <= 1'h1;
      @(posedge clk_in);
      msg_last_dma_done_in <= 1'h0;
      msg_active_in <= 1'h0;
      tick(0);
    end
    else
      tick(1);
    chk("busy_ack", 1'h0, busy_entered_n);
    chk("busy_bit", 1'h1, status_busy_bit_out);
    chk("auto_reply", 1'h1, auto_busy_reply_out);
    chk("dma_gated", 1'h0, dma_req_out);
    chk("mem_released", 1'h1, mem_bus_oe_n_out);
    @(posedge clk_in);
    force_busy_req_n <= 1'h1;
    tick(1);
    chk("busy_left", 1'h1, busy_entered_n);
    chk("dma_resumed", 1'h0, mem_bus_oe_n_out);
  endtask

  task automatic t_loop(input logic [2:0] m, input logic [15:0] ea,
                        input logic [15:0] eb, input logic e);
    // The fail flag is sticky; one disabled cycle clears the last verdict.
    @(posedge clk_in);
    loop_check_en_n <= 1'h1;
    @(posedge clk_in);
    {loop_check_en_n, cross_channel_diag_n, tx_chan_b_in} <= m;
    sent_valid_in <= 1'h1;
    sent_word_in <= 16'h5A3C;
    @(posedge clk_in);
    sent_valid_in <= 1'h0;
    {echo_a_valid_in, echo_b_valid_in} <= 2'h3;
    echo_a_word_in <= ea;
    echo_b_word_in <= eb;
    @(posedge clk_in);
    {echo_a_valid_in, echo_b_valid_in} <= 2'h0;
    tick(1);
    chk("loop_fail", e, loop_check_fail);
  endtask

  task automatic pulse_sample();
    @(posedge clk_in);
    legal_sampled_in <= 1'h1;
    @(posedge clk_in);
    legal_sampled_in <= 1'h0;
    #1;
  endtask

  task automatic t_field();
    @(posedge clk_in);
    cmd_word_in <= 16'hA5C3;
    cmd_valid_in <= 1'h1;
    @(posedge clk_in);
    cmd_word_in <= 16'h03C0;
    @(posedge clk_in);
    cmd_valid_in <= 1'h0;
    #1 chk("field_a", 11'h5C3, cmd_field_bus);
    chk("lgl_en_n", 1'h0, legality_logic_en_n);
    pulse_sample();
    chk("legal_a", 1'h1, cmd_legal_out);
    @(posedge clk_in);
    cmd_valid_in <= 1'h1;
    @(posedge clk_in);
    cmd_valid_in <= 1'h0;
    error_convention_sel <= 1'h0;
    err_valid_in <= 1'h1;
    err_word_count_in <= 5'h15;
    #1 chk("field_b", 11'h3C0, cmd_field_bus);
    @(posedge clk_in);
    error_convention_sel <= 1'h1;
    err_word_count_in <= 5'h0A;
    @(posedge clk_in);
    err_valid_in <= 1'h0;
    #1 chk("err_count", 11'h3D5, cmd_field_bus);
    pulse_sample();
    chk("legal_b", 1'h0, cmd_legal_out);
    chk("std_conv", 11'h3D5, cmd_field_bus);
    @(posedge clk_in);
    legality_method_sel <= 1'h1;
    pulse_sample();
    chk("mem_method", 1'h1, cmd_legal_out);
    chk("lgl_off", 1'h1, legality_logic_en_n);
  endtask

  initial
  begin
    // The reset level is set at time zero without an edge, so the state is
    // only known once a clock edge has passed under reset.
    @(posedge clk_in);
    #1 chk("rst_busy", 1'h1, busy_entered_n);
    chk("rst_field", LGL_RESET, cmd_field_bus);
    @(posedge clk_in);
    reset_n_in <= 1'h1;
    rd(ADDR_MASK, 8'h00, "mask_rst");
    rd(4'hF, 8'h00, "unmapped");
    t_busy(1'h0);
    t_busy(1'h1);
    t_loop(3'h4, 16'h0000, 16'hFFFF, 1'h0);
    t_loop(3'h2, 16'h5A3C, 16'h0000, 1'h0);
    t_loop(3'h3, 16'h0000, 16'h5A3C, 1'h0);
    t_loop(3'h0, 16'h0000, 16'h5A3C, 1'h0);
    t_loop(3'h1, 16'h5A3C, 16'h0000, 1'h0);
    t_loop(3'h0, 16'h5A3C, 16'h5A3D, 1'h1);
    t_field();
    rd(ADDR_LGLBUS, 8'hD5, "field_rd");
    rd(ADDR_STATE, 8'h04, "state_rd");
    rd(ADDR_STATUS, 8'h07, "status");
    wr(ADDR_MASK, 8'h01);
    chk("irq_on", 1'h1, irq_out);
    wr(ADDR_STATUS, 8'h01);
    chk("irq_off", 1'h0, irq_out);
    rd(ADDR_STATUS, 8'h06, "status_w1c");
    finish_test();
  end
endmodule
`default_nettype wire
